//--- src/rx_sig_pkg.sv
// Package: register map, field layout and carrier types of the receive signaling block
package rx_sig_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int unsigned SLOTS      = 24;
  localparam int unsigned SLOT_W     = 5;
  localparam int unsigned IDX_W      = 12;
  localparam int unsigned IDX_LSB    = 2;

  // ****************************************************************
  // Register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [IDX_W-1:0] IDX_FRAMER_CTRL = 12'h107;
  localparam logic [IDX_W-1:0] IDX_CTRL_BASE   = 12'h3a0;
  localparam logic [IDX_W-1:0] IDX_SUB_BASE    = 12'h3c0;
  localparam logic [IDX_W-1:0] IDX_RECV_BASE   = 12'h500;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int unsigned SF_ALIGN_BIT  = 7;
  localparam int unsigned SUB_EN_BIT    = 6;
  localparam int unsigned OH_EN_BIT     = 5;
  localparam int unsigned DEB_EN_BIT    = 4;
  localparam int unsigned SCHEME_LSB    = 2;
  localparam int unsigned EXTRACT_LSB   = 0;
  localparam int unsigned SIG_A         = 3;
  localparam int unsigned SIG_B         = 2;
  localparam int unsigned SIG_C         = 1;
  localparam int unsigned SIG_D         = 0;
  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  localparam logic [3:0]  SIG_RESET     = 4'h0;
  localparam logic [31:0] WORD_ZERO     = 32'h00000000;
  localparam logic [3:0]  ALL_ONES_SIG  = 4'hf;

  // ****************************************************************
  // Modes
  // ****************************************************************
  typedef enum logic [1:0] {
    SUB_ALL_ONES = 2'b00,
    SUB_16_CODE  = 2'b01,
    SUB_4_CODE   = 2'b10,
    SUB_2_CODE   = 2'b11
  } sub_scheme_type;

  typedef enum logic [1:0] {
    EXT_NONE    = 2'b00,
    EXT_16_CODE = 2'b01,
    EXT_4_CODE  = 2'b10,
    EXT_2_CODE  = 2'b11
  } ext_scheme_type;

  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic              valid;
    logic [SLOT_W-1:0] slot;
    logic [3:0]        abcd;
  } sig_word_type;

  typedef struct packed {
    logic              valid;
    logic [SLOT_W-1:0] slot;
    logic [7:0]        data;
    logic              robbed;
    logic [1:0]        sigSel;
  } pcm_word_type;

endpackage : rx_sig_pkg

//--- src/rx_signaling_substitute_array.sv
// Receive signaling substitution and received-signaling array, AHB-Lite slave
// Summary of operation
// (RL1) Substitute bit 3 replaces received A under 16-, 4- and 2-code.
// (RL2) Substitute bit 2 replaces received B under 16- and 4-code.
// (RL3) Substitute bits 1 and 0 replace C and D only under 16-code.
// (RL4) 24 read/write substitute registers at consecutive indices, reset 0.
// (RL5) A read-only array per slot holds the latest A,B,C,D, A highest.
// (RL6) With debounce on, a slot updates after 2 equal superframes.
// (RL7) With debounce on, differing consecutive superframes leave it alone.
// (RL8) With debounce on and the alignment bit set, updates land on a superframe boundary.
// (RL9) Debounce off or alignment bit clear updates at once, not on a boundary; debounce still needs 2 equal.
// (RL10) Software ignores the array unless robbed-bit signaling is on.
// (RL11) Substitution touches only the PCM stream, not array or pins.
// (RL12) A slot is substituted only while its substitution enable is one.
// (RL13) Scheme 00 forces ones, 01 16-code, 10 4-code, 11 2-code.
// (RL14) Extraction 00 none, 01 A-D, 10 A and B, 11 A only.
// (RL15) Both arrays are indexed by the slot on the receive path.
// (RL16) Reserved upper bits read zero and ignore writes.
//
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module rx_signaling_substitute_array (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // AHB-Lite slave
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic                  hready,
  input  wire logic [31:0]           hwdata,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  // Receive framer side
  input  wire rx_sig_pkg::sig_word_type recvSig,
  input  wire logic                  superframeEnd,
  input  wire rx_sig_pkg::pcm_word_type pcmIn,
  // Line outputs
  output rx_sig_pkg::pcm_word_type   pcmOutputStream,
  output rx_sig_pkg::sig_word_type   signalingOutputPin,
  output rx_sig_pkg::sig_word_type   overheadOutputPin,
  output logic                       superframeAlign
);
  import rx_sig_pkg::*;

  // ****************************************************************
  // Functions
  // ****************************************************************
  function automatic logic inRange(input logic [IDX_W-1:0] idx,
                                   input logic [IDX_W-1:0] base);
    logic [IDX_W-1:0] off;
    off = idx - base;
    inRange = (idx >= base) && (off < IDX_W'(SLOTS));
  endfunction : inRange

  // Offset inside a 24-entry window; only meaningful where inRange holds
  function automatic logic [SLOT_W-1:0] slotOf(input logic [IDX_W-1:0] idx,
                                              input logic [IDX_W-1:0] base);
    logic [IDX_W-1:0] off;
    off = idx - base;
    slotOf = off[SLOT_W-1:0];
  endfunction : slotOf

  // Keep only the bits the extraction scheme asks for
  // Bits left out are stored as zero rather than kept from before
  function automatic logic [3:0] extractMask(input ext_scheme_type ext,
                                             input logic [3:0] abcd);
    logic [3:0] m;
    m = SIG_RESET;
    unique case (ext)
      EXT_NONE:    m = SIG_RESET;
      EXT_16_CODE: m = abcd;
      EXT_4_CODE:  m = {abcd[SIG_A], abcd[SIG_B], 2'b00};
      EXT_2_CODE:  m = {abcd[SIG_A], 3'b000};
    endcase
    extractMask = m;
  endfunction : extractMask

  // Substitute value for robbed bit sel (0=A .. 3=D)
  // 4-code repeats A,B on C,D; 2-code puts A on every robbed bit
  function automatic logic subBit(input sub_scheme_type sch,
                                  input logic [3:0] v,
                                  input logic [1:0] sel);
    logic b;
    b = 1'b1;
    unique case (sch)
      // (RL13) all ones
      SUB_ALL_ONES: b = 1'b1;
      // (RL1) (RL3) 16-code A-D
      SUB_16_CODE:  b = v[SIG_A - int'(sel)];
      // (RL2) 4-code A,B
      SUB_4_CODE:   b = sel[0] ? v[SIG_B] : v[SIG_A];
      // (RL1) 2-code A only
      SUB_2_CODE:   b = v[SIG_A];
    endcase
    subBit = b;
  endfunction : subBit

  // ****************************************************************
  // Storage
  // ****************************************************************
  // Slot arrays are flops; slot numbers of 24 or more are refused before
  // any of them is indexed
  logic [7:0] ctrl_q     [SLOTS];
  logic [3:0] subVal_q   [SLOTS];
  logic [3:0] recvArr_q  [SLOTS];
  logic [3:0] prevSf_q   [SLOTS];
  logic [3:0] staged_q   [SLOTS];
  logic       pending_q  [SLOTS];
  logic       sfAlign_q;

  // ****************************************************************
  // AHB-Lite slave, zero wait states
  // Only NONSEQ transfers are decoded, of any size: hsize is not looked at, so
  // a narrow write still replaces the whole register
  // ****************************************************************
  logic             addrPhase;
  logic [IDX_W-1:0] aIdx;
  logic             wrPend_q;
  logic [IDX_W-1:0] wrIdx_q;
  logic [31:0]      rdData_d;

  assign addrPhase = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign aIdx      = haddr[IDX_W+IDX_LSB-1:IDX_LSB];

  // Write index waits for the data phase, where hwdata stands
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrPend_q <= 1'b0;
      wrIdx_q  <= '0;
    end else begin
      wrPend_q <= addrPhase && hwrite;
      if (addrPhase) begin
        wrIdx_q <= aIdx;
      end
    end
  end

  // Reads are decoded in the address phase and stand from a flop in
  // the data phase; unmapped indices read zero
  always_comb begin
    rdData_d = WORD_ZERO;
    if (aIdx == IDX_FRAMER_CTRL) begin
      rdData_d[SF_ALIGN_BIT] = sfAlign_q;
    end else if (inRange(aIdx, IDX_CTRL_BASE)) begin
      rdData_d[7:0] = ctrl_q[slotOf(aIdx, IDX_CTRL_BASE)];
    end else if (inRange(aIdx, IDX_SUB_BASE)) begin
      // (RL16) upper bits zero
      rdData_d[3:0] = subVal_q[slotOf(aIdx, IDX_SUB_BASE)];
    end else if (inRange(aIdx, IDX_RECV_BASE)) begin
      // (RL5) received A-D
      rdData_d[3:0] = recvArr_q[slotOf(aIdx, IDX_RECV_BASE)];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hrdata    <= WORD_ZERO;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      // Read data holds between reads; writes leave it alone
      if (addrPhase && !hwrite) begin
        hrdata <= rdData_d;
      end
    end
  end

  // Control registers, including the framer-wide alignment bit
  // Writes aimed at the received array match nothing here and are lost
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sfAlign_q <= 1'b0;
      for (int i = 0; i < SLOTS; i++) begin
        ctrl_q[i] <= CTRL_RESET;
      end
    end else if (wrPend_q) begin
      if (wrIdx_q == IDX_FRAMER_CTRL) begin
        sfAlign_q <= hwdata[SF_ALIGN_BIT];
      end else if (inRange(wrIdx_q, IDX_CTRL_BASE)) begin
        ctrl_q[slotOf(wrIdx_q, IDX_CTRL_BASE)] <= hwdata[7:0];
      end
    end
  end

  // (RL4) substitute registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < SLOTS; i++) begin
        subVal_q[i] <= SIG_RESET;
      end
    end else if (wrPend_q && inRange(wrIdx_q, IDX_SUB_BASE)) begin
      // (RL16) upper bits dropped
      subVal_q[slotOf(wrIdx_q, IDX_SUB_BASE)] <= hwdata[3:0];
    end
  end

  // ****************************************************************
  // Received signaling array update
  // ****************************************************************
  logic           sigSlotOk;
  logic [7:0]     sigCtrl;
  logic [3:0]     sigNew;
  logic           sigDeb;
  logic           sigUpdate;
  ext_scheme_type sigExt;

  // (RL15) indexed by receive slot
  assign sigSlotOk = recvSig.valid && (recvSig.slot < SLOT_W'(SLOTS));
  assign sigCtrl   = sigSlotOk ? ctrl_q[recvSig.slot] : CTRL_RESET;
  assign sigExt    = ext_scheme_type'(sigCtrl[EXTRACT_LSB +: 2]);
  assign sigDeb    = sigCtrl[DEB_EN_BIT];
  // (RL14) extraction masking
  assign sigNew    = extractMask(sigExt, recvSig.abcd);

  // History holds the extracted value, so a change in a bit that is not
  // extracted never holds an update back
  // (RL6) (RL7) two equal superframes needed when debouncing
  assign sigUpdate = sigSlotOk && (sigExt != EXT_NONE)
                     && (!sigDeb || (sigNew == prevSf_q[recvSig.slot]));

  // Every received word refreshes the history, extraction off included,
  // so turning debounce on later compares against live data
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < SLOTS; i++) begin
        prevSf_q[i] <= SIG_RESET;
      end
    end else if (sigSlotOk) begin
      prevSf_q[recvSig.slot] <= sigNew;
    end
  end

  // Deferred updates wait in a staging copy; an arrival in the same
  // cycle as the boundary is staged again rather than lost
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < SLOTS; i++) begin
        staged_q[i]  <= SIG_RESET;
        pending_q[i] <= 1'b0;
      end
    end else begin
      if (superframeEnd) begin
        for (int i = 0; i < SLOTS; i++) begin
          pending_q[i] <= 1'b0;
        end
      end
      // (RL8) defer to boundary
      if (sigUpdate && sigDeb && sfAlign_q) begin
        staged_q[recvSig.slot]  <= sigNew;
        pending_q[recvSig.slot] <= 1'b1;
      end else if (sigUpdate) begin
        // An immediate update must not be overwritten by an older staged
        // value when the next boundary comes
        pending_q[recvSig.slot] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < SLOTS; i++) begin
        recvArr_q[i] <= SIG_RESET;
      end
    end else begin
      // A value staged under the alignment bit still lands at the next
      // boundary if the bit is cleared meanwhile
      // (RL8) commit on boundary
      if (superframeEnd) begin
        for (int i = 0; i < SLOTS; i++) begin
          if (pending_q[i]) begin
            recvArr_q[i] <= staged_q[i];
          end
        end
      end
      // (RL9) immediate update
      if (sigUpdate && !(sigDeb && sfAlign_q)) begin
        recvArr_q[recvSig.slot] <= sigNew;
      end
    end
  end

  // ****************************************************************
  // PCM substitution and signaling outputs
  // ****************************************************************
  logic           pcmSlotOk;
  logic [7:0]     pcmCtrl;
  logic [7:0]     pcmData;
  logic [3:0]     pcmArr;
  sub_scheme_type pcmScheme;

  assign pcmSlotOk = pcmIn.valid && (pcmIn.slot < SLOT_W'(SLOTS));
  assign pcmCtrl   = pcmSlotOk ? ctrl_q[pcmIn.slot] : CTRL_RESET;
  assign pcmArr    = pcmSlotOk ? recvArr_q[pcmIn.slot] : SIG_RESET;
  assign pcmScheme = sub_scheme_type'(pcmCtrl[SCHEME_LSB +: 2]);

  // Only bit 0 of a robbed byte is replaced; the voice bits pass as is
  always_comb begin
    pcmData = pcmIn.data;
    // (RL12) only when enabled
    if (pcmSlotOk && pcmIn.robbed && pcmCtrl[SUB_EN_BIT]) begin
      pcmData[0] = subBit(pcmScheme, subVal_q[pcmIn.slot], pcmIn.sigSel);
    end
  end

  // Slot and flags pass through; only valid and data are rebuilt
  // (RL11) substitution reaches only the PCM stream
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pcmOutputStream <= '0;
    end else begin
      pcmOutputStream       <= pcmIn;
      pcmOutputStream.valid <= pcmSlotOk;
      pcmOutputStream.data  <= pcmData;
    end
  end

  // Pins show the array itself, never the substitute values
  // The overhead copy repeats the array, gated per slot by its enable
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      signalingOutputPin <= '0;
      overheadOutputPin  <= '0;
      superframeAlign    <= 1'b0;
    end else begin
      signalingOutputPin.valid <= pcmSlotOk;
      signalingOutputPin.slot  <= pcmIn.slot;
      signalingOutputPin.abcd  <= pcmArr;
      overheadOutputPin.valid  <= pcmSlotOk && pcmCtrl[OH_EN_BIT];
      overheadOutputPin.slot   <= pcmIn.slot;
      overheadOutputPin.abcd   <= pcmArr;
      superframeAlign          <= sfAlign_q;
    end
  end

endmodule : rx_signaling_substitute_array

`default_nettype wire

//--- test/rx_sig_monitor.sv
// Port checker of the receive signaling block
`timescale 1ns/1ps
`default_nettype none
module rx_sig_monitor (
  // Clock, reset and bus
  input wire logic                     clk,
  input wire logic                     rst,
  input wire logic                     hsel,
  input wire logic [31:0]              haddr,
  input wire logic [1:0]               htrans,
  input wire logic                     hwrite,
  input wire logic                     hready,
  input wire logic [31:0]              hrdata,
  input wire logic                     hreadyout,
  input wire logic                     hresp,
  // Line side
  input wire rx_sig_pkg::sig_word_type recvSig,
  input wire logic                     superframeEnd,
  input wire rx_sig_pkg::pcm_word_type pcmIn,
  input wire rx_sig_pkg::pcm_word_type pcmOutputStream,
  input wire rx_sig_pkg::sig_word_type signalingOutputPin,
  input wire logic                     superframeAlign
);
  import rx_sig_pkg::*;
  // *****
  // Properties
  // *****
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [11:0] idx;
  logic        rdReq;
  logic        arrIdx;
  logic        inSlot;
  assign idx    = haddr[13:2];
  assign rdReq  = hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
  assign arrIdx = (idx >= IDX_SUB_BASE && idx < IDX_SUB_BASE + 12'h018)
               || (idx >= IDX_RECV_BASE && idx < IDX_RECV_BASE + 12'h018);
  assign inSlot = pcmIn.valid && pcmIn.slot < 5'h18;
  a_ready_high: assert property (hreadyout)
    else $error("bus stalled");
  a_resp_okay: assert property (!hresp)
    else $error("error response");
  a_read_upper: assert property (rdReq |=> hrdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_read_reserved: assert property (rdReq && arrIdx |=>
    hrdata[7:4] == 4'h0) else $error("reserved bits set");
  a_pcm_slot: assert property (inSlot |-> ##1 pcmOutputStream.valid
    && pcmOutputStream.slot == $past(pcmIn.slot)) else $error("pcm slot lost");
  a_pcm_drop: assert property (pcmIn.valid && !inSlot |=>
    !pcmOutputStream.valid) else $error("bad slot passed");
  a_pcm_idle: assert property (!pcmIn.valid |=> !pcmOutputStream.valid)
    else $error("pcm valid without input");
  a_pin_slot: assert property (inSlot |=> signalingOutputPin.valid
    && signalingOutputPin.slot == $past(pcmIn.slot)) else $error("pin slot");
  a_clear_pass: assert property (inSlot && !pcmIn.robbed |=>
    pcmOutputStream.data == $past(pcmIn.data)) else $error("clear byte");
  a_high_bits: assert property (inSlot && pcmIn.robbed |=>
    (pcmOutputStream.data >> 1) == ($past(pcmIn.data) >> 1))
    else $error("upper pcm bits");
  c_robbed: cover property (inSlot && pcmIn.robbed);
  c_sig: cover property (recvSig.valid);
  c_aligned: cover property (superframeEnd && superframeAlign);
endmodule : rx_sig_monitor

bind rx_signaling_substitute_array rx_sig_monitor i_rx_sig_monitor (
  .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .recvSig(recvSig),
  .superframeEnd(superframeEnd), .pcmIn(pcmIn),
  .pcmOutputStream(pcmOutputStream),
  .signalingOutputPin(signalingOutputPin),
  .superframeAlign(superframeAlign));
`default_nettype wire

//--- test/rx_framer_model.sv
// Behavioural receive framer feeding signaling words and PCM bytes
`timescale 1ns/1ps
`default_nettype none
module rx_framer_model (
  // Clock
  input  wire logic                clk,
  // Toward the signaling block
  output rx_sig_pkg::sig_word_type recvSig,
  output logic                     superframeEnd,
  output rx_sig_pkg::pcm_word_type pcmIn
);
  import rx_sig_pkg::*;
  int pace = 32'h91000360;
  initial begin
    recvSig       = '0;
    superframeEnd = 1'b0;
    pcmIn         = '0;
  end
  // Slow or prompt delivery; a released word shows the inverse, not stale data
  task automatic sig(input logic [4:0] s, input logic [3:0] v);
    repeat (1 + $unsigned($random(pace)) % 3) @(posedge clk);
    recvSig <= '{1'b1, s, v};
    @(posedge clk);
    recvSig <= '{1'b0, s, ~v};
  endtask : sig
  task automatic pcm(input logic [4:0] s, input logic [7:0] d,
                     input logic rb, input logic [1:0] sel);
    @(posedge clk);
    pcmIn <= '{1'b1, s, d, rb, sel};
    @(posedge clk);
    pcmIn <= '{1'b0, s, ~d, rb, sel};
  endtask : pcm
  task automatic sf;
    @(posedge clk);
    superframeEnd <= 1'b1;
    @(posedge clk);
    superframeEnd <= 1'b0;
  endtask : sf
endmodule : rx_framer_model
`default_nettype wire

//--- test/tb_rx_signaling_substitute_array.sv
// Self-checking testbench of the receive signaling block
`timescale 1ns/1ps
`default_nettype none
module tb_rx_signaling_substitute_array;
  import rx_sig_pkg::*;
  logic         clk, rst, hsel, hwrite, hreadyout, hresp;
  logic  [31:0] haddr, hwdata, hrdata, rd, w;
  logic  [1:0]  htrans;
  logic  [2:0]  hsize;
  logic         superframeEnd, superframeAlign;
  sig_word_type recvSig, signalingOutputPin, overheadOutputPin;
  pcm_word_type pcmIn, pcmOutputStream;
  int           miscompares = 0;
  int           comparisons = 0;
  int           seed = 32'h91000360;
  logic  [3:0]  v, r;
  logic  [7:0]  d;
  logic  [4:0]  s;

  rx_signaling_substitute_array i_rx_signaling_substitute_array (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .recvSig(recvSig), .superframeEnd(superframeEnd), .pcmIn(pcmIn),
    .pcmOutputStream(pcmOutputStream),
    .signalingOutputPin(signalingOutputPin),
    .overheadOutputPin(overheadOutputPin),
    .superframeAlign(superframeAlign));
  rx_framer_model i_rx_framer_model (.clk(clk), .recvSig(recvSig),
    .superframeEnd(superframeEnd), .pcmIn(pcmIn));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic give_verdict;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Zero-wait slave, yet the master still waits for ready
  task automatic bus(input logic wr, input logic [11:0] i,
                     input logic [31:0] wd);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    haddr  <= {18'h0, i, 2'b00};
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic rdchk(input logic [11:0] i, input logic [31:0] exp);
    bus(1'b0, i, WORD_ZERO);
    check(rd, exp);
  endtask : rdchk

  function automatic logic [3:0] ext(input logic [1:0] e, input logic [3:0] x);
    case (e)
      2'b00: return 4'h0;
      2'b01: return x;
      2'b10: return {x[3:2], 2'b00};
      default: return {x[3], 3'b000};
    endcase
  endfunction : ext

  function automatic logic subbit(input logic [1:0] sc, input logic [3:0] x,
                                  input logic [1:0] sel);
    case (sc)
      2'b00: return 1'b1;
      2'b01: return x[3 - sel];
      2'b10: return sel[0] ? x[2] : x[3];
      default: return x[3];
    endcase
  endfunction : subbit

  initial begin
    #500000;
    miscompares++;
    give_verdict();
  end

  // *****
  // Scenarios
  // *****
  initial begin
    rst    = 1'b1;
    hsel   = 1'b0;
    haddr  = WORD_ZERO;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize  = 3'b010;
    hwdata = WORD_ZERO;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 24; i += 23) begin
      rdchk(IDX_RECV_BASE + 12'(i), WORD_ZERO);
      rdchk(IDX_SUB_BASE + 12'(i), WORD_ZERO);
      w = $random(seed);
      bus(1'b1, IDX_SUB_BASE + 12'(i), w);
      rdchk(IDX_SUB_BASE + 12'(i), {28'h0, w[3:0]});
      bus(1'b1, IDX_RECV_BASE + 12'(i), 32'hffffffff);
      rdchk(IDX_RECV_BASE + 12'(i), WORD_ZERO);
    end
    bus(1'b1, 12'h3d8, 32'hffffffff);
    rdchk(12'h3d8, WORD_ZERO);
    for (int e = 0; e < 4; e++) begin
      bus(1'b1, IDX_CTRL_BASE + 12'(e), 32'(e));
      v = 4'($random(seed)) | 4'h1;
      i_rx_framer_model.sig(5'(e), v);
      rdchk(IDX_RECV_BASE + 12'(e), {28'h0, ext(2'(e), v)});
    end
    bus(1'b1, IDX_CTRL_BASE + 12'h007, 32'h11);
    i_rx_framer_model.sig(5'h07, v);
    rdchk(IDX_RECV_BASE + 12'h007, WORD_ZERO);
    i_rx_framer_model.sig(5'h07, v);
    rdchk(IDX_RECV_BASE + 12'h007, {28'h0, v});
    i_rx_framer_model.sig(5'h07, ~v);
    rdchk(IDX_RECV_BASE + 12'h007, {28'h0, v});
    bus(1'b1, IDX_FRAMER_CTRL, 32'h80);
    bus(1'b1, IDX_CTRL_BASE + 12'h009, 32'h11);
    check(32'(superframeAlign), 32'h1);
    i_rx_framer_model.sig(5'h09, v);
    i_rx_framer_model.sf();
    i_rx_framer_model.sig(5'h09, v);
    rdchk(IDX_RECV_BASE + 12'h009, WORD_ZERO);
    i_rx_framer_model.sf();
    rdchk(IDX_RECV_BASE + 12'h009, {28'h0, v});
    bus(1'b1, IDX_CTRL_BASE + 12'h00a, 32'h01);
    i_rx_framer_model.sig(5'h0a, v);
    rdchk(IDX_RECV_BASE + 12'h00a, {28'h0, v});
    bus(1'b1, IDX_FRAMER_CTRL, WORD_ZERO);
    for (int sc = 0; sc < 4; sc++) begin
      s = 5'($unsigned($random(seed)) % 24);
      r = 4'($random(seed));
      v = 4'($random(seed));
      bus(1'b1, IDX_CTRL_BASE + 12'(s), 32'h01);
      i_rx_framer_model.sig(s, v);
      bus(1'b1, IDX_SUB_BASE + 12'(s), {28'h0, r});
      bus(1'b1, IDX_CTRL_BASE + 12'(s), {25'h0, 2'b11, 1'b0, 2'(sc), 2'b01});
      for (int sel = 0; sel < 4; sel++) begin
        d = 8'($random(seed));
        i_rx_framer_model.pcm(s, d, 1'b1, 2'(sel));
        #1;
        check(32'(pcmOutputStream.data[0]), 32'(subbit(2'(sc), r, 2'(sel))));
        check(32'(signalingOutputPin.abcd), 32'(v));
        check(32'(overheadOutputPin.abcd), 32'(v));
        check(32'(overheadOutputPin.valid), 32'h1);
      end
      bus(1'b1, IDX_CTRL_BASE + 12'(s), 32'h01);
      i_rx_framer_model.pcm(s, ~d, 1'b1, 2'b00);
      #1;
      check({24'h0, pcmOutputStream.data}, {24'h0, ~d});
      check(32'(overheadOutputPin.valid), 32'h0);
    end
    repeat (40) begin
      i_rx_framer_model.pcm(5'($random(seed)), 8'($random(seed)),
                            1'($random(seed)), 2'($random(seed)));
    end
    give_verdict();
  end
endmodule : tb_rx_signaling_substitute_array
`default_nettype wire
